// ===== rss_step_assign.sv
// Behaviour
// - a 4-bit step code 3h..Ah enables its rail at step 3..10.
// - 4-bit codes 0h..2h and Bh..Fh keep the rail away from the sequencer.
// - register 0x23 holds buck 4 (7-4, reset 7h) and buck 3 (3-0, reset 5h).
// - register 0x24 holds backup b (5-4) and a (1-0); other bits read 0.
// - a backup code 1h enables at step 1, 2h at step 2, 0h/3h not at all.
// - steps 1 and 2 run only while the seal flag is 0, else are skipped.
// - once the seal is broken the backup rails are never switched off.
// - register 0x25 holds switch 1 (7-4, reset 6h) and linear (3-0, 3h).
// - each power-up gap waits 2 ms or 5 ms as its select bit says.
// - the delay factor bit multiplies power-down gaps by ten only.
`timescale 1ns/1ps
`default_nettype none
`include "rss_cfg.svh"

module rss_step_assign
  import rss_pkg::*;
#(
  parameter int unsigned DLY_SHORT_CYC = 32'(`RSS_DLY_SHORT_CYC),
  parameter int unsigned DLY_LONG_CYC = 32'(`RSS_DLY_LONG_CYC)
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire rss_reg_req_s reg_req,
  input wire logic reg_unlocked,
  output logic [7:0] reg_rdata,
  input wire logic freshness_seal_flag,
  input wire logic [8:0] gap_long_sel,
  input wire logic power_down_delay_factor,
  input wire logic pwr_up_req,
  input wire logic pwr_dn_req,
  output rss_rail_en_s rail_en,
  output logic [3:0] cur_step,
  output logic seq_busy
);

  // ----------------------------------------------------------------
  // step decode
  // ----------------------------------------------------------------
  function automatic logic [3:0] wide_step(input logic [3:0] code);
    if (code >= `RSS_WIDE_FIRST && code <= `RSS_WIDE_LAST) begin
      wide_step = code;
    end else begin
      wide_step = 4'h0;
    end
  endfunction : wide_step

  function automatic logic [3:0] narrow_step(input logic [1:0] code);
    if (code == 2'h1 || code == 2'h2) begin
      narrow_step = {2'h0, code};
    end else begin
      narrow_step = 4'h0;
    end
  endfunction : narrow_step

  // ----------------------------------------------------------------
  // step registers
  // ----------------------------------------------------------------
  logic [7:0] buck34_q, buck34_d;
  logic [7:0] backup_q, backup_d;
  logic [7:0] swlin_q, swlin_d;
  logic [7:0] rdata_q, rdata_d;

  always_comb begin
    buck34_d = buck34_q;
    backup_d = backup_q;
    swlin_d = swlin_q;
    // locked writes are dropped silently
    if (reg_req.wr && reg_unlocked) begin
      case (reg_req.addr)
        `RSS_ADDR_BUCK34: buck34_d = reg_req.wdata;
        `RSS_ADDR_BACKUP: begin
          backup_d = reg_req.wdata & `RSS_BACKUP_MASK;
        end
        `RSS_ADDR_SWLIN: swlin_d = reg_req.wdata;
        default: ;
      endcase
    end
    case (reg_req.addr)
      `RSS_ADDR_BUCK34: rdata_d = buck34_q;
      `RSS_ADDR_BACKUP: rdata_d = backup_q;
      `RSS_ADDR_SWLIN: rdata_d = swlin_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      buck34_q <= `RSS_RST_BUCK34;
      backup_q <= `RSS_RST_BACKUP;
      swlin_q <= `RSS_RST_SWLIN;
      rdata_q <= 8'h00;
    end else begin
      buck34_q <= buck34_d;
      backup_q <= backup_d;
      swlin_q <= swlin_d;
      rdata_q <= rdata_d;
    end
  end

  // read data lags the address by one cycle, so a read needs no strobe
  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  rss_state_e state_q, state_d;
  logic [3:0] step_q, step_d;
  logic [31:0] wait_q, wait_d;
  rss_rail_en_s en_q, en_d;
  rss_rail_en_s hit;
  logic [3:0] first_step;
  logic gap_bit;
  logic [31:0] gap_cyc;

  always_comb begin
    hit.buck3 = wide_step(buck34_q[`RSS_LO_NIB]) == step_q;
    hit.buck4 = wide_step(buck34_q[`RSS_HI_NIB]) == step_q;
    hit.backup_a = narrow_step(backup_q[`RSS_BACKUP_A]) == step_q;
    hit.backup_b = narrow_step(backup_q[`RSS_BACKUP_B]) == step_q;
    hit.switch1 = wide_step(swlin_q[`RSS_HI_NIB]) == step_q;
    hit.linear = wide_step(swlin_q[`RSS_LO_NIB]) == step_q;
    // a broken seal drops steps 1 and 2 from both directions
    first_step = freshness_seal_flag ? `RSS_STEP_SEALED
                                     : `RSS_STEP_FIRST;
    // gap bit i sits between step i+1 and step i+2
    // index runs past bit 8 only where no wait is loaded: at a final fire, in the on state, in the down wait at step 10, or in idle after reset
    if (state_q == RSS_DN_FIRE) begin
      gap_bit = gap_long_sel[4'(step_q - 4'h2)];
    end else begin
      gap_bit = gap_long_sel[4'(step_q - 4'h1)];
    end
    gap_cyc = gap_bit ? DLY_LONG_CYC : DLY_SHORT_CYC;
    if (state_q == RSS_DN_FIRE && power_down_delay_factor) begin
      gap_cyc = 32'(gap_cyc * `RSS_DN_FACTOR);
    end
  end

  always_comb begin
    state_d = state_q;
    step_d = step_q;
    wait_d = wait_q;
    en_d = en_q;
    case (state_q)
      RSS_IDLE: begin
        if (pwr_up_req) begin
          step_d = first_step;
          state_d = RSS_UP_FIRE;
        end
      end
      RSS_UP_FIRE: begin
        en_d = en_q | hit;
        if (step_q == `RSS_STEP_LAST) begin
          state_d = RSS_ON;
        end else begin
          wait_d = gap_cyc - 32'd1;
          state_d = RSS_UP_WAIT;
        end
      end
      RSS_UP_WAIT: begin
        if (wait_q == 32'd0) begin
          step_d = step_q + 4'h1;
          state_d = RSS_UP_FIRE;
        end else begin
          wait_d = wait_q - 32'd1;
        end
      end
      RSS_ON: begin
        if (pwr_dn_req) begin
          step_d = `RSS_STEP_LAST;
          state_d = RSS_DN_FIRE;
        end
      end
      RSS_DN_FIRE: begin
        en_d = en_q & ~hit;
        if (freshness_seal_flag) begin
          en_d.backup_a = en_q.backup_a;
          en_d.backup_b = en_q.backup_b;
        end
        if (step_q <= first_step) begin
          state_d = RSS_IDLE;
        end else begin
          wait_d = gap_cyc - 32'd1;
          state_d = RSS_DN_WAIT;
        end
      end
      RSS_DN_WAIT: begin
        if (wait_q == 32'd0) begin
          step_d = step_q - 4'h1;
          state_d = RSS_DN_FIRE;
        end else begin
          wait_d = wait_q - 32'd1;
        end
      end
      default: state_d = RSS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= RSS_IDLE;
      step_q <= 4'h0;
      wait_q <= 32'h0;
      en_q <= '0;
    end else begin
      state_q <= state_d;
      step_q <= step_d;
      wait_q <= wait_d;
      en_q <= en_d;
    end
  end

  assign rail_en = en_q;
  assign cur_step = step_q;
  assign seq_busy = state_q != RSS_IDLE && state_q != RSS_ON;

endmodule : rss_step_assign

`default_nettype wire

// ===== rss_cfg.svh
`ifndef RSS_CFG_SVH
`define RSS_CFG_SVH

// ----------------------------------------------------------------
// register offsets and reset values
// ----------------------------------------------------------------
`define RSS_ADDR_BUCK34 8'h23
`define RSS_ADDR_BACKUP 8'h24
`define RSS_ADDR_SWLIN 8'h25
`define RSS_RST_BUCK34 8'h75
`define RSS_RST_BACKUP 8'h12
`define RSS_RST_SWLIN 8'h63
`define RSS_BACKUP_MASK 8'h33

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RSS_HI_NIB 7:4
`define RSS_LO_NIB 3:0
`define RSS_BACKUP_B 5:4
`define RSS_BACKUP_A 1:0

// ----------------------------------------------------------------
// step codes
// ----------------------------------------------------------------
`define RSS_WIDE_FIRST 4'h3
`define RSS_WIDE_LAST 4'hA
`define RSS_STEP_FIRST 4'h1
`define RSS_STEP_SEALED 4'h3
`define RSS_STEP_LAST 4'hA

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RSS_CLK_HZ 64'd25000000
`define RSS_DLY_SHORT_US 64'd2000
`define RSS_DLY_LONG_US 64'd5000
`define RSS_DN_FACTOR 32'd10
`define RSS_DLY_SHORT_CYC \
  (`RSS_DLY_SHORT_US * `RSS_CLK_HZ / 64'd1000000)
`define RSS_DLY_LONG_CYC \
  (`RSS_DLY_LONG_US * `RSS_CLK_HZ / 64'd1000000)

`endif

// ===== rss_pkg.sv
`default_nettype none

package rss_pkg;

  // gray in listed order from idle to down wait; up fire -> on and down fire -> idle flip two bits
  typedef enum logic [2:0] {
    RSS_IDLE    = 3'h0,
    RSS_UP_FIRE = 3'h1,
    RSS_UP_WAIT = 3'h3,
    RSS_ON      = 3'h2,
    RSS_DN_FIRE = 3'h6,
    RSS_DN_WAIT = 3'h7
  } rss_state_e;

  typedef struct packed {
    logic buck3;
    logic buck4;
    logic backup_a;
    logic backup_b;
    logic switch1;
    logic linear;
  } rss_rail_en_s;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rss_reg_req_s;

endpackage : rss_pkg

`default_nettype wire

// ===== rss_step_assign_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module rss_step_assign_monitor
  import rss_pkg::*;
#(
  parameter int unsigned DLY_SHORT_CYC = 4,
  parameter int unsigned DLY_LONG_CYC = 10
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire rss_reg_req_s reg_req,
  input wire logic reg_unlocked,
  input wire logic [7:0] reg_rdata,
  input wire logic freshness_seal_flag,
  input wire logic pwr_up_req,
  input wire rss_rail_en_s rail_en,
  input wire logic [3:0] cur_step,
  input wire logic seq_busy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // cycles since cur_step last moved
  logic [31:0] run_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      run_q <= '0;
    end else begin
      run_q <= $changed(cur_step) ? 32'h0 : run_q + 32'h1;
    end
  end
  rsvd_zero_a: assert property (reg_req.addr == 8'h24 |=>
    (reg_rdata & 8'hCC) == 8'h00) else $error("reserved bits set");
  unmapped_zero_a: assert property (!(reg_req.addr inside
    {8'h23, 8'h24, 8'h25}) |=> reg_rdata == 8'h00) else $error("bad read");
  wr_store_a: assert property ((reg_req.wr && reg_unlocked &&
    reg_req.addr == 8'h23) ##1 reg_req.addr == 8'h23 |=>
    reg_rdata == $past(reg_req.wdata, 2)) else $error("write lost");
  first_step_a: assert property ($rose(seq_busy) &&
    $past(pwr_up_req) |-> cur_step == ($past(freshness_seal_flag) ?
    4'h3 : 4'h1)) else $error("wrong first step");
  step_walk_a: assert property (seq_busy && $past(seq_busy) &&
    $changed(cur_step) |-> cur_step == $past(cur_step) + 4'h1 ||
    cur_step == $past(cur_step) - 4'h1) else $error("step skipped");
  gap_range_a: assert property (seq_busy && $past(seq_busy) &&
    $changed(cur_step) |-> run_q >= DLY_SHORT_CYC &&
    run_q <= 32'd10 * DLY_LONG_CYC) else $error("gap out of range");
  rail_rise_a: assert property ((6'(rail_en) & ~6'($past(rail_en)))
    != 6'h00 |-> $past(seq_busy)) else $error("rail rose while idle");
  backup_keep_a: assert property (freshness_seal_flag &&
    $past(freshness_seal_flag) |-> !$fell(rail_en.backup_a) &&
    !$fell(rail_en.backup_b)) else $error("backup rail dropped");
  cover property ($rose(seq_busy) && freshness_seal_flag);
  cover property ($rose(seq_busy) && !freshness_seal_flag);
  cover property (reg_req.wr && !reg_unlocked);
  cover property ($fell(seq_busy) && freshness_seal_flag);
endmodule : rss_step_assign_monitor
bind rss_step_assign rss_step_assign_monitor #(
  .DLY_SHORT_CYC(DLY_SHORT_CYC), .DLY_LONG_CYC(DLY_LONG_CYC)) u_mon (
  .sys_clk(sys_clk), .rst_b(rst_b), .reg_req(reg_req),
  .reg_unlocked(reg_unlocked), .reg_rdata(reg_rdata),
  .freshness_seal_flag(freshness_seal_flag), .pwr_up_req(pwr_up_req),
  .rail_en(rail_en), .cur_step(cur_step), .seq_busy(seq_busy));
`default_nettype wire

// ===== rss_rail_model.sv
`timescale 1ns/1ps
`default_nettype none
// rails report good RAMP cycles after enable, drop at once
module rss_rail_model
  import rss_pkg::*;
#(
  parameter int unsigned RAMP = 2
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire rss_rail_en_s rail_en,
  output rss_rail_en_s rail_good
);
  logic [RAMP-1:0][5:0] ramp_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ramp_q <= '0;
    end else begin
      ramp_q <= {ramp_q[RAMP-2:0], 6'(rail_en)};
    end
  end
  assign rail_good = rss_rail_en_s'(ramp_q[RAMP-1] & 6'(rail_en));
endmodule : rss_rail_model
`default_nettype wire

// ===== rss_step_assign_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module rss_step_assign_test import rss_pkg::*;;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  rss_reg_req_s reg_req = '0;
  logic reg_unlocked = 1'b0;
  logic freshness_seal_flag = 1'b0;
  logic pwr_up_req = 1'b0;
  logic pwr_dn_req = 1'b0;
  logic [8:0] gap_long_sel = 9'h0A5;
  logic power_down_delay_factor = 1'b0;
  localparam int DLY_SHORT = 4;
  localparam int DLY_LONG = 10;
  logic [7:0] reg_rdata;
  logic [3:0] cur_step;
  logic seq_busy;
  rss_rail_en_s rail_en, rail_good, keep;
  int n_errors = 0, checked = 0, cycles = 0;
  // per run: 0x23, 0x24, 0x25 contents
  logic [7:0] cfg [3][3] = '{'{8'hA3, 8'h12, 8'hB2},
    '{8'h48, 8'h30, 8'h6F}, '{8'h57, 8'h21, 8'h90}};
  always #20 sys_clk = ~sys_clk;
  rss_step_assign #(.DLY_SHORT_CYC(DLY_SHORT),
    .DLY_LONG_CYC(DLY_LONG)) i_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_req(reg_req),
    .reg_unlocked(reg_unlocked), .reg_rdata(reg_rdata),
    .freshness_seal_flag(freshness_seal_flag), .gap_long_sel(gap_long_sel),
    .power_down_delay_factor(power_down_delay_factor),
    .pwr_up_req(pwr_up_req),
    .pwr_dn_req(pwr_dn_req), .rail_en(rail_en), .cur_step(cur_step),
    .seq_busy(seq_busy));
  rss_rail_model #(.RAMP(2)) i_rails (.sys_clk(sys_clk), .rst_b(rst_b),
    .rail_en(rail_en), .rail_good(rail_good));
  function automatic logic on_w(logic [3:0] c, logic [3:0] s);
    return c >= 4'h3 && c <= 4'hA && c <= s;
  endfunction : on_w
  function automatic logic on_b(logic [1:0] c, logic [3:0] s, logic sl);
    return !sl && c inside {2'h1, 2'h2} && {2'h0, c} <= s;
  endfunction : on_b
  function automatic rss_rail_en_s exp_at(int k, logic [3:0] s, logic sl);
    exp_at = keep;
    exp_at.buck3 |= on_w(cfg[k][0][3:0], s);
    exp_at.buck4 |= on_w(cfg[k][0][7:4], s);
    exp_at.backup_a |= on_b(cfg[k][1][1:0], s, sl);
    exp_at.backup_b |= on_b(cfg[k][1][5:4], s, sl);
    exp_at.switch1 |= on_w(cfg[k][2][7:4], s);
    exp_at.linear |= on_w(cfg[k][2][3:0], s);
  endfunction : exp_at
  // spacing between two step fires: one fire cycle plus the gap
  function automatic int gap_exp(int b, logic x10);
    gap_exp = (gap_long_sel[b] ? DLY_LONG : DLY_SHORT) * (x10 ? 10 : 1) + 1;
  endfunction : gap_exp
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic wr(logic [7:0] a, logic [7:0] d, logic u);
    @(posedge sys_clk);
    reg_req <= '{1'b1, a, d};
    reg_unlocked <= u;
    @(posedge sys_clk);
    reg_req.wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge sys_clk);
    reg_req.addr <= a;
    @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK(reg_rdata, e)
  endtask : rd
  task automatic kick(logic up);
    @(posedge sys_clk);
    pwr_up_req <= up;
    pwr_dn_req <= !up;
    @(posedge sys_clk);
    pwr_up_req <= 1'b0;
    pwr_dn_req <= 1'b0;
    while (seq_busy !== 1'b1) @(negedge sys_clk);
  endtask : kick
  task automatic run_up(int k, logic sl);
    int t;
    int f;
    f = sl ? 3 : 1;
    kick(1'b1);
    t = cycles;
    for (int s = f; s <= 10; s++) begin
      while (cur_step !== 4'(s)) @(negedge sys_clk);
      if (s > f) `CHK(cycles - t, gap_exp(s - 2, 1'b0))
      t = cycles;
      @(negedge sys_clk);
      `CHK(rail_en, exp_at(k, 4'(s), sl))
    end
    while (seq_busy !== 1'b0) @(negedge sys_clk);
  endtask : run_up
  task automatic run_dn(rss_rail_en_s e);
    int t;
    kick(1'b0);
    t = cycles;
    for (int s = 9; s >= (freshness_seal_flag ? 3 : 1); s--) begin
      while (cur_step !== 4'(s)) @(negedge sys_clk);
      `CHK(cycles - t, gap_exp(s - 1, power_down_delay_factor))
      t = cycles;
    end
    while (seq_busy !== 1'b0) @(negedge sys_clk);
    repeat (3) @(negedge sys_clk);
    `CHK(rail_en, e)
    `CHK(rail_good, e)
  endtask : run_dn
  // hang guard, well above the longest expected run
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(8'h23, 8'h75);
    rd(8'h24, 8'h12);
    rd(8'h25, 8'h63);
    rd(8'h26, 8'h00);
    wr(8'h25, 8'hA0, 1'b0);
    rd(8'h25, 8'h63);
    wr(8'h24, 8'hFF, 1'b1);
    rd(8'h24, 8'h33);
    keep = '0;
    for (int k = 0; k < 3; k++) begin
      // factor on for the middle run only, so both scalings are seen
      @(posedge sys_clk);
      power_down_delay_factor <= (k == 1);
      for (int r = 0; r < 3; r++) wr(8'h23 + 8'(r), cfg[k][r], 1'b1);
      run_up(k, 1'b0);
      if (k < 2) run_dn('0);
    end
    rd(8'h23, 8'h57);
    @(posedge sys_clk);
    freshness_seal_flag <= 1'b1;
    keep.backup_a = 1'b1;
    keep.backup_b = 1'b1;
    run_dn(keep);
    run_up(2, 1'b1);
    tally_and_finish();
  end
endmodule : rss_step_assign_test
`default_nettype wire
